//--- core/servo_cfg_defs.svh
`ifndef SERVO_CFG_DEFS_SVH
`define SERVO_CFG_DEFS_SVH

// register indices on the plain register port
`define A_RMS_TC 4'h0
`define A_LIMSEL 4'h1
`define A_CCW_DRV 4'h2
`define A_CCW_ABS 4'h3
`define A_CW_DRV 4'h4
`define A_CW_ABS 4'h5
`define A_SINGLE 4'h6
`define A_NUM 4'h7
`define A_DEN 4'h8
`define A_POINT 4'h9
`define A_IN_MASK 4'ha
`define A_OUT_MASK 4'hb
`define A_STATUS 4'hc
`define A_SPEED 4'hd
`define A_RMS 4'he

// reset values and legal ranges
`define RMS_TC_RST 6'h1e
`define RMS_TC_MIN 6'h01
`define RMS_TC_MAX 6'h3c
`define LIMSEL_RST 8'h11
`define LIM_TENS_MAX 4'h2
`define LIM_UNITS_MAX 4'h1
`define PCT_FULL 10'h3e8
`define SINGLE_RST 10'h000
`define RATIO_RST 15'h0001
`define RATIO_MIN 15'h0001
`define POINT_RST 3'h0
`define IN_MASK_RST 9'h000
`define OUT_MASK_RST 8'h00

// timing: filter tick of one millisecond
`define CLK_NS 20
`define TICK_NS 1000000
`define MS_CYCLES (`TICK_NS / `CLK_NS)
`define RMS_SHIFT 10
`define SPEED_SAT 16'h7fff

`endif

//--- core/servo_cfg_pkg.sv
package servo_cfg_pkg;
  typedef enum logic [1:0] {
    LM_ANALOG = 2'b00,
    LM_GATED = 2'b01,
    LM_ALWAYS = 2'b10
  } limit_method_t;

  typedef enum logic {
    SC_IDLE = 1'b0,
    SC_RUN = 1'b1
  } scale_state_t;
endpackage

//--- core/speed_scaler.sv
`include "servo_cfg_defs.svh"

module speed_scaler
  import servo_cfg_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic start, // begin one conversion
  input wire logic signed [15:0] speed, // motor speed
  input wire logic [14:0] num, // ratio numerator
  input wire logic [14:0] den, // ratio denominator
  output logic done, // result valid pulse
  output logic signed [15:0] result // scaled speed
);
  scale_state_t state_reg;
  logic [31:0] div_reg;
  logic [14:0] rem_reg;
  logic [4:0] cnt_reg;
  logic neg_reg;
  logic [15:0] mag;
  logic [15:0] trial;
  logic [15:0] diff;
  logic qbit;

  assign mag = speed[15] ? 16'(-speed) : 16'(speed);
  assign trial = {rem_reg, div_reg[31]};
  assign qbit = trial >= {1'b0, den};
  assign diff = qbit ? 16'(trial - {1'b0, den}) : trial;

  // shift-subtract divide: one quotient bit per clock, 32 clocks
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= SC_IDLE;
      div_reg <= 32'h0;
      rem_reg <= 15'h0;
      cnt_reg <= 5'h0;
      neg_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        SC_IDLE: begin
          if (start) begin
            div_reg <= 32'(mag * num);
            rem_reg <= 15'h0;
            cnt_reg <= 5'h1f;
            neg_reg <= speed[15];
            state_reg <= SC_RUN;
          end
        end
        SC_RUN: begin
          div_reg <= {div_reg[30:0], qbit};
          rem_reg <= diff[14:0];
          cnt_reg <= 5'(cnt_reg - 5'h1);
          if (cnt_reg == 5'h0) begin
            state_reg <= SC_IDLE;
          end
        end
      endcase
    end
  end

  // full quotient as it stands after the last shift, clipped to the
  // largest positive display value before the sign goes back on
  logic [31:0] quot;
  logic [15:0] sat;
  assign quot = {div_reg[30:0], qbit};
  assign sat = (quot > 32'(`SPEED_SAT)) ? `SPEED_SAT : quot[15:0];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      done <= 1'b0;
      result <= 16'sh0;
    end else begin
      done <= (state_reg == SC_RUN) && (cnt_reg == 5'h0);
      if (state_reg == SC_RUN && cnt_reg == 5'h0) begin
        result <= neg_reg ? 16'(-sat) : sat;
      end
    end
  end

endmodule

//--- core/servo_limit_and_io_config.sv
// Behaviour
// - each discrete input whose bit is set in the nine-bit input mask is inverted.
// - each discrete output whose bit is set in the eight-bit output mask is inverted.
// - both inversion masks reset to zero, so nothing is inverted by default.
// - the display point position takes 0 to 7, 0 none, 1 lowest digit, 7 highest, default 0.
// - displayed speed is motor speed times numerator over denominator, each 1 to 32767, default 1.
// - the scaled speed drives both the internal and the external display.
// - limit selection takes 00 to 21, default 11, tens digit torque method, units speed method.
// - method 0 limits torque from the analog input, 10 V meaning peak, only while enable is on.
// - method 1 applies the single limit, or the quadrant limits if it is zero, while enable is on.
// - method 2 applies the single limit, or the quadrant limits if zero, ignoring enable.
// - separate ccw and cw drive limits, 0 to 100.0 percent, default 100 percent.
// - separate ccw and cw absorb limits, 0 to 100.0 percent, default 100 percent.
// - rms torque is filtered with a time constant of 1 to 60 s, default 30 s.
`include "servo_cfg_defs.svh"

module servo_limit_and_io_config
  import servo_cfg_pkg::*;
#(
  parameter int MS_CYCLES = `MS_CYCLES, // cycles per filter tick
  parameter int ADC_10V = 2047, // analog code at +10 V
  parameter int TLE_BIT = 1 // input carrying torque limit enable
) (
  input wire logic clk, // 50 MHz clock
  input wire logic resetn, // sync reset, active low
  input wire logic [3:0] addr, // register index
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata, // read data, cycle after rd
  input wire logic [8:0] din_pins, // discrete input terminals
  output logic [8:0] din_corr, // polarity-corrected inputs
  input wire logic [7:0] dout_int, // internal output states
  output logic [7:0] dout_pins, // discrete output terminals
  input wire logic signed [11:0] analog_torque_input, // +-10 V code
  input wire logic signed [15:0] motor_speed, // motor speed
  input wire logic signed [15:0] torque_now, // present torque
  output logic [9:0] lim_ccw_drive, // 0.1 percent units
  output logic [9:0] lim_ccw_absorb, // 0.1 percent units
  output logic [9:0] lim_cw_drive, // 0.1 percent units
  output logic [9:0] lim_cw_absorb, // 0.1 percent units
  output logic limit_active, // a torque limit is in force
  output logic [1:0] speed_limit_method, // units digit
  output logic signed [15:0] speed_display, // internal display
  output logic signed [15:0] ext_display_value, // external display
  output logic [6:0] ext_display_point, // one-hot point, bit0 lsd
  output logic [15:0] rms_torque_readout // filtered rms torque
);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [5:0] rms_tc_reg;
  logic [7:0] limsel_reg;
  logic [9:0] ccw_drv_reg;
  logic [9:0] ccw_abs_reg;
  logic [9:0] cw_drv_reg;
  logic [9:0] cw_abs_reg;
  logic [9:0] single_reg;
  logic [14:0] num_reg;
  logic [14:0] den_reg;
  logic [2:0] point_reg;
  logic [8:0] in_mask_reg;
  logic [7:0] out_mask_reg;

  function automatic logic pct_ok(input logic [15:0] v);
    return v <= 16'(`PCT_FULL);
  endfunction

  function automatic logic ratio_ok(input logic [15:0] v);
    return v[15] == 1'b0 && v[14:0] >= `RATIO_MIN;
  endfunction

  function automatic logic is_wr(input logic [3:0] a);
    return wr && addr == a;
  endfunction

  // out-of-range writes are dropped so settings stay legal
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rms_tc_reg <= `RMS_TC_RST;
      limsel_reg <= `LIMSEL_RST;
      ccw_drv_reg <= `PCT_FULL;
      ccw_abs_reg <= `PCT_FULL;
      cw_drv_reg <= `PCT_FULL;
      cw_abs_reg <= `PCT_FULL;
      single_reg <= `SINGLE_RST;
      num_reg <= `RATIO_RST;
      den_reg <= `RATIO_RST;
      point_reg <= `POINT_RST;
      in_mask_reg <= `IN_MASK_RST;
      out_mask_reg <= `OUT_MASK_RST;
    end else begin
      if (is_wr(`A_RMS_TC) && wdata >= 16'(`RMS_TC_MIN) &&
          wdata <= 16'(`RMS_TC_MAX)) begin
        rms_tc_reg <= wdata[5:0];
      end
      if (is_wr(`A_LIMSEL) && wdata[15:8] == 8'h0 &&
          wdata[7:4] <= `LIM_TENS_MAX &&
          wdata[3:0] <= `LIM_UNITS_MAX) begin
        limsel_reg <= wdata[7:0];
      end
      if (is_wr(`A_CCW_DRV) && pct_ok(wdata)) begin
        ccw_drv_reg <= wdata[9:0];
      end
      if (is_wr(`A_CCW_ABS) && pct_ok(wdata)) begin
        ccw_abs_reg <= wdata[9:0];
      end
      if (is_wr(`A_CW_DRV) && pct_ok(wdata)) begin
        cw_drv_reg <= wdata[9:0];
      end
      if (is_wr(`A_CW_ABS) && pct_ok(wdata)) begin
        cw_abs_reg <= wdata[9:0];
      end
      if (is_wr(`A_SINGLE) && pct_ok(wdata)) begin
        single_reg <= wdata[9:0];
      end
      if (is_wr(`A_NUM) && ratio_ok(wdata)) begin
        num_reg <= wdata[14:0];
      end
      if (is_wr(`A_DEN) && ratio_ok(wdata)) begin
        den_reg <= wdata[14:0];
      end
      if (is_wr(`A_POINT) && wdata[15:3] == 13'h0) begin
        point_reg <= wdata[2:0];
      end
      if (is_wr(`A_IN_MASK) && wdata[15:9] == 7'h0) begin
        in_mask_reg <= wdata[8:0];
      end
      if (is_wr(`A_OUT_MASK) && wdata[15:8] == 8'h0) begin
        out_mask_reg <= wdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // polarity correction at the terminals
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      din_corr <= 9'h0;
      dout_pins <= 8'h0;
    end else begin
      din_corr <= din_pins ^ in_mask_reg;
      dout_pins <= dout_int ^ out_mask_reg;
    end
  end

  // ----------------------------------------
  // torque limit selection
  // ----------------------------------------
  limit_method_t method;
  logic tle;
  logic [11:0] adc_mag;
  logic [21:0] adc_scaled;
  logic [9:0] adc_pct;

  assign method = limit_method_t'(limsel_reg[5:4]);
  assign tle = din_corr[TLE_BIT];
  assign speed_limit_method = limsel_reg[1:0];
  assign adc_mag = analog_torque_input[11] ? 12'(-analog_torque_input)
                                           : 12'(analog_torque_input);
  // constant divisor, so this folds to a multiply in synthesis
  assign adc_scaled = 22'((32'(adc_mag) * 32'(`PCT_FULL)) / ADC_10V);
  assign adc_pct = (adc_scaled > 22'(`PCT_FULL)) ? `PCT_FULL
                                                 : adc_scaled[9:0];

  logic act;
  logic use_analog;
  always_comb begin
    act = 1'b0;
    use_analog = 1'b0;
    unique case (method)
      LM_ANALOG: begin
        act = tle;
        use_analog = 1'b1;
      end
      LM_GATED: act = tle;
      LM_ALWAYS: act = 1'b1;
      default: act = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      limit_active <= 1'b0;
      lim_ccw_drive <= `PCT_FULL;
      lim_ccw_absorb <= `PCT_FULL;
      lim_cw_drive <= `PCT_FULL;
      lim_cw_absorb <= `PCT_FULL;
    end else begin
      limit_active <= act;
      if (!act) begin
        lim_ccw_drive <= `PCT_FULL;
        lim_ccw_absorb <= `PCT_FULL;
        lim_cw_drive <= `PCT_FULL;
        lim_cw_absorb <= `PCT_FULL;
      end else if (use_analog) begin
        lim_ccw_drive <= adc_pct;
        lim_ccw_absorb <= adc_pct;
        lim_cw_drive <= adc_pct;
        lim_cw_absorb <= adc_pct;
      end else if (single_reg != `SINGLE_RST) begin
        lim_ccw_drive <= single_reg;
        lim_ccw_absorb <= single_reg;
        lim_cw_drive <= single_reg;
        lim_cw_absorb <= single_reg;
      end else begin
        lim_ccw_drive <= ccw_drv_reg;
        lim_ccw_absorb <= ccw_abs_reg;
        lim_cw_drive <= cw_drv_reg;
        lim_cw_absorb <= cw_abs_reg;
      end
    end
  end

  // ----------------------------------------
  // speed display scaling
  // ----------------------------------------
  logic sc_done;
  logic sc_busy_reg;
  logic signed [15:0] sc_result;

  speed_scaler u_scaler (
    .clk(clk),
    .resetn(resetn),
    .start(!sc_busy_reg),
    .speed(motor_speed),
    .num(num_reg),
    .den(den_reg),
    .done(sc_done),
    .result(sc_result)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sc_busy_reg <= 1'b0;
      speed_display <= 16'sh0;
      ext_display_value <= 16'sh0;
    end else begin
      sc_busy_reg <= sc_busy_reg ? !sc_done : 1'b1;
      if (sc_done) begin
        speed_display <= sc_result;
        ext_display_value <= sc_result;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_display_point <= 7'h0;
    end else if (point_reg == `POINT_RST) begin
      ext_display_point <= 7'h0;
    end else begin
      ext_display_point <= 7'(7'h1 << (point_reg - 3'h1));
    end
  end

  // ----------------------------------------
  // rms torque filter
  // ----------------------------------------
  // first-order filter of torque squared, stepped every tc ms with
  // gain 2^-10, so the time constant is about 1.024 * tc seconds
  logic [31:0] ms_cnt_reg;
  logic [5:0] tc_cnt_reg;
  logic [31:0] msq_reg;
  logic [31:0] tq_sq;
  logic [15:0] tq_mag;
  logic step;

  assign tq_mag = torque_now[15] ? 16'(-torque_now) : 16'(torque_now);
  assign tq_sq = 32'(tq_mag * tq_mag);
  assign step = (ms_cnt_reg == 32'(MS_CYCLES - 1)) &&
                (tc_cnt_reg >= rms_tc_reg - 6'h1);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ms_cnt_reg <= 32'h0;
      tc_cnt_reg <= 6'h0;
    end else if (ms_cnt_reg == 32'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= 32'h0;
      tc_cnt_reg <= step ? 6'h0 : 6'(tc_cnt_reg + 6'h1);
    end else begin
      ms_cnt_reg <= 32'(ms_cnt_reg + 32'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      msq_reg <= 32'h0;
    end else if (step) begin
      msq_reg <= 32'(msq_reg - (msq_reg >> `RMS_SHIFT) +
                     (tq_sq >> `RMS_SHIFT));
    end
  end

  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [15:0] r;
    r = 16'h0;
    for (int i = 15; i >= 0; i--) begin
      if (32'((r | (16'h1 << i)) * (r | (16'h1 << i))) <= v) begin
        r = r | (16'h1 << i);
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rms_torque_readout <= 16'h0;
    end else begin
      rms_torque_readout <= isqrt(msq_reg);
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || !rd) begin
      rdata <= 16'h0;
    end else begin
      unique case (addr)
        `A_RMS_TC: rdata <= 16'(rms_tc_reg);
        `A_LIMSEL: rdata <= 16'(limsel_reg);
        `A_CCW_DRV: rdata <= 16'(ccw_drv_reg);
        `A_CCW_ABS: rdata <= 16'(ccw_abs_reg);
        `A_CW_DRV: rdata <= 16'(cw_drv_reg);
        `A_CW_ABS: rdata <= 16'(cw_abs_reg);
        `A_SINGLE: rdata <= 16'(single_reg);
        `A_NUM: rdata <= 16'(num_reg);
        `A_DEN: rdata <= 16'(den_reg);
        `A_POINT: rdata <= 16'(point_reg);
        `A_IN_MASK: rdata <= 16'(in_mask_reg);
        `A_OUT_MASK: rdata <= 16'(out_mask_reg);
        `A_STATUS: rdata <= {6'h0, din_corr, limit_active};
        `A_SPEED: rdata <= speed_display;
        `A_RMS: rdata <= rms_torque_readout;
        default: rdata <= 16'h0;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_in_inv;
    @(posedge clk) disable iff (!resetn)
    ##1 din_corr == ($past(din_pins) ^ $past(in_mask_reg));
  endproperty
  a_in_inv: assert property (p_in_inv)
    else $error("input inversion wrong");

  property p_out_inv;
    @(posedge clk) disable iff (!resetn)
    ##1 dout_pins == ($past(dout_int) ^ $past(out_mask_reg));
  endproperty
  a_out_inv: assert property (p_out_inv)
    else $error("output inversion wrong");

  property p_mask_rst;
    @(posedge clk) !resetn |=> in_mask_reg == 9'h0 && out_mask_reg == 8'h0;
  endproperty
  a_mask_rst: assert property (p_mask_rst)
    else $error("masks not cleared by reset");

  property p_point;
    @(posedge clk) disable iff (!resetn)
    point_reg == 3'h0 |=> ext_display_point == 7'h0;
  endproperty
  a_point: assert property (p_point)
    else $error("point shown at position zero");

  sequence s_start;
    !sc_busy_reg;
  endsequence
  sequence s_done;
    ##[30:36] sc_done;
  endsequence
  property p_scale;
    @(posedge clk) disable iff (!resetn)
    s_start |-> s_done;
  endproperty
  a_scale: assert property (p_scale)
    else $error("speed scaling did not finish");

  property p_disp_same;
    @(posedge clk) disable iff (!resetn)
    speed_display == ext_display_value;
  endproperty
  a_disp_same: assert property (p_disp_same)
    else $error("displays disagree");

  property p_limsel;
    @(posedge clk) disable iff (!resetn)
    limsel_reg[7:4] <= 4'h2 && limsel_reg[3:0] <= 4'h1;
  endproperty
  a_limsel: assert property (p_limsel)
    else $error("limit selection out of range");

  property p_gate;
    @(posedge clk) disable iff (!resetn)
    method != LM_ALWAYS && !tle |=> !limit_active &&
      lim_cw_drive == 10'h3e8 && lim_ccw_absorb == 10'h3e8;
  endproperty
  a_gate: assert property (p_gate)
    else $error("limit applied while enable off");

  property p_always;
    @(posedge clk) disable iff (!resetn)
    method == LM_ALWAYS && single_reg == 10'h0
      |=> limit_active && lim_ccw_drive == $past(ccw_drv_reg) &&
          lim_cw_absorb == $past(cw_abs_reg);
  endproperty
  a_always: assert property (p_always)
    else $error("quadrant limits not applied");

  property p_tc;
    @(posedge clk) disable iff (!resetn)
    rms_tc_reg >= 6'h1 && rms_tc_reg <= 6'h3c;
  endproperty
  a_tc: assert property (p_tc)
    else $error("time constant out of range");
endmodule

//--- bench/ctrl_model.sv
module ctrl_model #(
  parameter int MACHINE_CYCLE_S = 15 // seconds per machine cycle
) (
  input wire logic clk, // system clock
  input wire logic [8:0] level_req, // wanted terminal levels
  input wire logic signed [11:0] code_req, // wanted analog code
  output logic [8:0] din_pins, // raw input terminals
  output logic signed [11:0] analog_torque_input, // analog command
  output logic [5:0] tc_hint // suggested rms time constant
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // machine controller side
  // ----------------------------------------
  // advice only: the device never checks it
  assign tc_hint = 6'(2 * MACHINE_CYCLE_S);
  // terminals move one edge after a request, like a real plc scan
  always @(posedge clk) begin
    din_pins <= level_req;
    analog_torque_input <= code_req;
  end
endmodule

//--- bench/servo_limit_and_io_config_tb.sv
`include "servo_cfg_defs.svh"

module servo_limit_and_io_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, rms_torque_readout;
  logic [8:0] level_req = 9'h000, din_pins, din_corr;
  logic [7:0] dout_int = 8'h00, dout_pins;
  logic signed [11:0] code_req = 12'sh000, analog_torque_input;
  logic signed [15:0] motor_speed = 16'sh0000, torque_now = 16'sh0000;
  logic signed [15:0] speed_display, ext_display_value;
  logic [9:0] lim_ccw_drive, lim_ccw_absorb, lim_cw_drive, lim_cw_absorb;
  logic limit_active;
  logic [1:0] speed_limit_method;
  logic [6:0] ext_display_point;
  logic [5:0] tc_hint;
  int fails = 0, compares = 0;
  localparam logic [15:0] RST_TAB [12] = '{16'h001e, 16'h0011, 16'h03e8,
    16'h03e8, 16'h03e8, 16'h03e8, 16'h0000, 16'h0001, 16'h0001,
    16'h0000, 16'h0000, 16'h0000};

  always #10 clk = ~clk;

  servo_limit_and_io_config #(.MS_CYCLES(10), .ADC_10V(2047), .TLE_BIT(1))
    u_servo_limit_and_io_config (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .din_pins(din_pins),
    .din_corr(din_corr), .dout_int(dout_int), .dout_pins(dout_pins),
    .analog_torque_input(analog_torque_input), .motor_speed(motor_speed),
    .torque_now(torque_now), .lim_ccw_drive(lim_ccw_drive),
    .lim_ccw_absorb(lim_ccw_absorb), .lim_cw_drive(lim_cw_drive),
    .lim_cw_absorb(lim_cw_absorb), .limit_active(limit_active),
    .speed_limit_method(speed_limit_method), .speed_display(speed_display),
    .ext_display_value(ext_display_value),
    .ext_display_point(ext_display_point),
    .rms_torque_readout(rms_torque_readout));

  ctrl_model u_ctrl_model (.clk(clk), .level_req(level_req),
    .code_req(code_req), .din_pins(din_pins),
    .analog_torque_input(analog_torque_input), .tc_hint(tc_hint));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask

  // pins need one edge in the model, one to correct, one for limits
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic lim_chk(input logic [9:0] a, b, c, d, input logic act);
    settle();
    chk("ccw drive", {6'h0, a}, {6'h0, lim_ccw_drive});
    chk("ccw absorb", {6'h0, b}, {6'h0, lim_ccw_absorb});
    chk("cw drive", {6'h0, c}, {6'h0, lim_cw_drive});
    chk("cw absorb", {6'h0, d}, {6'h0, lim_cw_absorb});
    chk("limit active", {15'h0, act}, {15'h0, limit_active});
  endtask

  task automatic drive(input logic [8:0] lv, input logic signed [11:0] cd);
    @(posedge clk);
    level_req <= lv;
    code_req <= cd;
  endtask

  task automatic spd_chk(input logic signed [15:0] s, input logic [15:0] n,
                         input logic [15:0] dn, input logic [15:0] exp);
    reg_wr(`A_NUM, n);
    reg_wr(`A_DEN, dn);
    @(posedge clk);
    motor_speed <= s;
    // a conversion already in flight may finish on stale inputs
    for (int i = 0; i < 200 && speed_display !== exp; i++) @(posedge clk);
    #1;
    chk("speed display", exp, speed_display);
    chk("ext display", exp, ext_display_value);
    rd_chk("speed reg", `A_SPEED, exp);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 12; i++) rd_chk("reset", i[3:0], RST_TAB[i]);
    rd_chk("unmapped", 4'hf, 16'h0000);
    @(posedge clk);
    #1;
    chk("rdata gone", 16'h0000, rdata);
    lim_chk(10'h3e8, 10'h3e8, 10'h3e8, 10'h3e8, 1'b0);
  endtask

  task automatic t_masks();
    reg_wr(`A_IN_MASK, 16'h008c);
    reg_wr(`A_OUT_MASK, 16'h004a);
    reg_wr(`A_IN_MASK, 16'h0200);
    drive(9'h0f0, 12'sh000);
    dout_int <= 8'h0f;
    settle();
    chk("din corr", 16'h007c, {7'h0, din_corr});
    chk("dout pins", 16'h0045, {8'h0, dout_pins});
    rd_chk("status", `A_STATUS, 16'h00f8);
    reg_wr(`A_IN_MASK, 16'h01ff);
    reg_wr(`A_OUT_MASK, 16'h00ff);
    drive(9'h000, 12'sh000);
    dout_int <= 8'h00;
    settle();
    chk("din all", 16'h01ff, {7'h0, din_corr});
    chk("dout all", 16'h00ff, {8'h0, dout_pins});
    reg_wr(`A_IN_MASK, 16'h0000);
    reg_wr(`A_OUT_MASK, 16'h0000);
  endtask

  task automatic t_quadrant();
    reg_wr(`A_CCW_DRV, 16'h01f4);
    reg_wr(`A_CCW_ABS, 16'h0000);
    reg_wr(`A_CCW_ABS, 16'h03e9);
    reg_wr(`A_CW_DRV, 16'h03e8);
    reg_wr(`A_CW_ABS, 16'h007b);
    reg_wr(`A_LIMSEL, 16'h0020);
    lim_chk(10'h1f4, 10'h000, 10'h3e8, 10'h07b, 1'b1);
    reg_wr(`A_SINGLE, 16'h00fa);
    lim_chk(10'h0fa, 10'h0fa, 10'h0fa, 10'h0fa, 1'b1);
    reg_wr(`A_LIMSEL, 16'h0010);
    lim_chk(10'h3e8, 10'h3e8, 10'h3e8, 10'h3e8, 1'b0);
    drive(9'h002, 12'sh000);
    lim_chk(10'h0fa, 10'h0fa, 10'h0fa, 10'h0fa, 1'b1);
    reg_wr(`A_SINGLE, 16'h0000);
    lim_chk(10'h1f4, 10'h000, 10'h3e8, 10'h07b, 1'b1);
  endtask

  task automatic t_analog();
    reg_wr(`A_LIMSEL, 16'h0000);
    drive(9'h002, 12'sh7ff);
    lim_chk(10'h3e8, 10'h3e8, 10'h3e8, 10'h3e8, 1'b1);
    drive(9'h002, 12'sh3ff);
    lim_chk(10'h1f3, 10'h1f3, 10'h1f3, 10'h1f3, 1'b1);
    drive(9'h002, -12'sh3ff);
    lim_chk(10'h1f3, 10'h1f3, 10'h1f3, 10'h1f3, 1'b1);
    drive(9'h000, 12'sh3ff);
    lim_chk(10'h3e8, 10'h3e8, 10'h3e8, 10'h3e8, 1'b0);
    reg_wr(`A_IN_MASK, 16'h0002);
    lim_chk(10'h1f3, 10'h1f3, 10'h1f3, 10'h1f3, 1'b1);
    reg_wr(`A_IN_MASK, 16'h0000);
  endtask

  task automatic t_limsel();
    reg_wr(`A_LIMSEL, 16'h0021);
    settle();
    chk("speed method", 16'h0001, {14'h0, speed_limit_method});
    reg_wr(`A_LIMSEL, 16'h0022);
    reg_wr(`A_LIMSEL, 16'h0120);
    rd_chk("limsel", `A_LIMSEL, 16'h0021);
    reg_wr(`A_LIMSEL, 16'h0011);
  endtask

  task automatic t_speed();
    spd_chk(16'sd1000, 16'h0003, 16'h0002, 16'd1500);
    spd_chk(-16'sd1001, 16'h0001, 16'h0002, -16'sd500);
    spd_chk(16'sd30000, 16'h0002, 16'h0001, 16'h7fff);
    spd_chk(16'sd1234, 16'h7fff, 16'h7fff, 16'd1234);
    reg_wr(`A_NUM, 16'h0000);
    rd_chk("num kept", `A_NUM, 16'h7fff);
  endtask

  task automatic t_point();
    for (int p = 1; p < 8; p++) begin
      reg_wr(`A_POINT, 16'(p));
      settle();
      chk("point", 16'(7'h01 << (p - 1)), {9'h0, ext_display_point});
    end
    reg_wr(`A_POINT, 16'h0008);
    rd_chk("point kept", `A_POINT, 16'h0007);
    reg_wr(`A_POINT, 16'h0000);
    settle();
    chk("no point", 16'h0000, {9'h0, ext_display_point});
  endtask

  task automatic t_rms();
    reg_wr(`A_RMS_TC, 16'h003c);
    reg_wr(`A_RMS_TC, 16'h0000);
    reg_wr(`A_RMS_TC, 16'h003d);
    rd_chk("tc max", `A_RMS_TC, 16'h003c);
    reg_wr(`A_RMS_TC, 16'h0001);
    rd_chk("tc min", `A_RMS_TC, 16'h0001);
    rd_chk("rms idle", `A_RMS, 16'h0000);
    @(posedge clk);
    torque_now <= 16'sd1000;
    for (int i = 0; i < 300 && rms_torque_readout === 16'h0; i++)
      @(posedge clk);
    #1;
    chk("rms first step", 16'h001f, rms_torque_readout);
    reg_wr(`A_RMS_TC, {10'h0, tc_hint});
    rd_chk("tc hint", `A_RMS_TC, 16'h001e);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic report_and_stop();
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    // whole sequence takes well under a thousand cycles
    repeat (30000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_masks();
    t_quadrant();
    t_analog();
    t_limsel();
    t_speed();
    t_point();
    t_rms();
    report_and_stop();
  end
endmodule
